// ---- bench/tb.sv ----
// self-checking bench for the type-c pin mode logic
// assumes the host model resolves every shared open-drain wire
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
	logic                         ref_clk = 1'b0, rstn = 1'b0, cc_enable_low = 1'b1, soft_reset = 1'b0;
	logic                         bus_data_pull = 1'b0, bus_clock_pull = 1'b0, hd = 1'b0, hc = 1'b0;
	tcpm_pkg::tcpm_level_type     addr_strap = tcpm_pkg::TCPM_LVL_OPEN, port_strap = tcpm_pkg::TCPM_LVL_OPEN;
	tcpm_pkg::tcpm_level_type     current_strap = tcpm_pkg::TCPM_LVL_LOW;
	tcpm_pkg::tcpm_cc_status_type cc_status = '0;
	logic                         data_or_current_lo_in, data_or_current_lo_out, data_or_current_lo_oe_n;
	logic                         clock_or_current_hi_in, clock_or_current_hi_out, clock_or_current_hi_oe_n;
	logic                         irq_or_audio_detect_out, irq_or_audio_detect_oe_n, irq_wire;
	logic                         vconn_overcurrent_flag, vconn_overcurrent_oe_n;
	logic                         source_attach_out, source_attach_oe_n, bus_data_in, bus_clock_in, cc_running;
	tcpm_pkg::tcpm_bus_mode_type  bus_mode;
	tcpm_pkg::tcpm_role_type      port_role, exp_role;
	tcpm_pkg::tcpm_current_type   advertised_current;
	int                           miscompares = 0, checked = 0;

	always #2.5 ref_clk = ~ref_clk;

	tcpm_pin_mode dut_u (.ref_clk, .rstn, .addr_strap, .port_strap, .current_strap, .cc_enable_low,
		.soft_reset, .cc_status, .bus_data_pull, .bus_clock_pull, .data_or_current_lo_in,
		.data_or_current_lo_out, .data_or_current_lo_oe_n, .clock_or_current_hi_in,
		.clock_or_current_hi_out, .clock_or_current_hi_oe_n, .irq_or_audio_detect_out,
		.irq_or_audio_detect_oe_n, .vconn_overcurrent_flag, .vconn_overcurrent_oe_n, .source_attach_out,
		.source_attach_oe_n, .bus_data_in, .bus_clock_in, .bus_mode, .port_role, .advertised_current,
		.cc_running);

	tcpm_host_model host_u (.data_oe_n(data_or_current_lo_oe_n), .clock_oe_n(clock_or_current_hi_oe_n),
		.irq_oe_n(irq_or_audio_detect_oe_n), .host_data_pull(hd), .host_clock_pull(hc),
		.data_wire(data_or_current_lo_in), .clock_wire(clock_or_current_hi_in), .irq_wire(irq_wire));

	function automatic tcpm_pkg::tcpm_role_type role_of(tcpm_pkg::tcpm_level_type l);
		if (l == tcpm_pkg::TCPM_LVL_LOW)
			return tcpm_pkg::TCPM_ROLE_UFP;
		if (l == tcpm_pkg::TCPM_LVL_HIGH)
			return tcpm_pkg::TCPM_ROLE_DFP;
		return tcpm_pkg::TCPM_ROLE_DRP;
	endfunction : role_of

	task automatic give_verdict();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	// one random cycle of straps, status and bus traffic, checked two edges later
	task automatic step();
		tcpm_pkg::tcpm_level_type     a;
		tcpm_pkg::tcpm_level_type     c;
		tcpm_pkg::tcpm_cc_status_type s;
		logic                         bd, bc, h1, h2, ufp;
		a = tcpm_pkg::tcpm_level_type'($urandom % 3);
		c = tcpm_pkg::tcpm_level_type'($urandom % 3);
		s = 7'($urandom);
		s.detected_current = tcpm_pkg::tcpm_current_type'($urandom % 3);
		{bd, bc, h1, h2} = 4'($urandom);
		// host stays off the shared pins while they are gpio outputs
		if (a == tcpm_pkg::TCPM_LVL_OPEN)
			{h1, h2} = 2'h0;
		@(posedge ref_clk);
		addr_strap <= a;
		current_strap <= c;
		cc_status <= s;
		port_strap <= tcpm_pkg::tcpm_level_type'($urandom % 3);
		bus_data_pull <= bd;
		bus_clock_pull <= bc;
		hd <= h1;
		hc <= h2;
		// pin pulls follow the registered bus mode through the registered pin, so a strap change settles two edges later
		repeat (2) @(posedge ref_clk);
		#1;
		ufp = exp_role == tcpm_pkg::TCPM_ROLE_UFP || !s.acting_source;
		if (a == tcpm_pkg::TCPM_LVL_OPEN) begin
			`CHK(bus_mode.i2c_enabled, 1'b0)
			`CHK({bus_data_in, bus_clock_in}, 2'h3)
			`CHK(irq_wire, ~s.audio_accessory)
			`CHK(data_or_current_lo_in, !ufp || s.detected_current == tcpm_pkg::TCPM_CUR_DEFAULT)
			`CHK(clock_or_current_hi_in, !ufp || s.detected_current != tcpm_pkg::TCPM_CUR_HIGH)
			// strap codes low/open/high line up with default/medium/high
			`CHK(advertised_current, ufp ? tcpm_pkg::TCPM_CUR_DEFAULT : tcpm_pkg::tcpm_current_type'(c))
		end else begin
			`CHK(bus_mode, {1'b1, (a == tcpm_pkg::TCPM_LVL_HIGH) ? 7'h67 : 7'h47})
			`CHK(irq_wire, ~s.regs_changed)
			`CHK(data_or_current_lo_in, ~(bd | h1))
			`CHK(clock_or_current_hi_in, ~(bc | h2))
			`CHK(bus_data_in, ~(bd | h1))
			`CHK(bus_clock_in, ~(bc | h2))
			`CHK(advertised_current, tcpm_pkg::TCPM_CUR_DEFAULT)
		end
		`CHK(vconn_overcurrent_oe_n, ~s.vconn_overcurrent)
		`CHK(source_attach_oe_n, ~(s.attached & s.acting_source))
		`CHK({data_or_current_lo_out, clock_or_current_hi_out, source_attach_out}, 3'h0)
		`CHK({irq_or_audio_detect_out, vconn_overcurrent_flag}, 2'h0)
		`CHK(port_role, exp_role)
		`CHK(cc_running, 1'b1)
	endtask : step

	initial begin
		#25000;
		miscompares++;
		give_verdict();
	end

	initial begin
		tcpm_pkg::tcpm_level_type l;
		void'($urandom(32'h6a38));
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(port_role, tcpm_pkg::TCPM_ROLE_DRP)
		`CHK({irq_or_audio_detect_oe_n, vconn_overcurrent_oe_n, source_attach_oe_n}, 3'h7)
		`CHK({data_or_current_lo_oe_n, clock_or_current_hi_oe_n}, 2'h3)
		@(posedge ref_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			l = tcpm_pkg::tcpm_level_type'(i);
			@(posedge ref_clk);
			cc_enable_low <= 1'b1;
			port_strap <= l;
			repeat (2) @(posedge ref_clk);
			#1;
			`CHK(cc_running, 1'b0)
			@(posedge ref_clk);
			cc_enable_low <= 1'b0;
			repeat (3) @(posedge ref_clk);
			#1;
			exp_role = role_of(l);
			`CHK(port_role, exp_role)
			repeat (60) step();
			l = tcpm_pkg::tcpm_level_type'((i + 1) % 3);
			@(posedge ref_clk);
			port_strap <= l;
			soft_reset <= 1'b1;
			@(posedge ref_clk);
			soft_reset <= 1'b0;
			repeat (3) @(posedge ref_clk);
			#1;
			exp_role = role_of(l);
			`CHK(port_role, exp_role)
		end
		give_verdict();
	end
endmodule : tb

// ---- bench/tcpm_host_model.sv ----
// host side of the shared pins: board pull-ups plus the host bus drivers
// assumes device pins are open-drain, oe_n low while pulling
`timescale 1ns/1ps
module tcpm_host_model (
	// device side
	input  wire logic data_oe_n,
	input  wire logic clock_oe_n,
	input  wire logic irq_oe_n,
	// host bus drivers, high = pull low
	input  wire logic host_data_pull,
	input  wire logic host_clock_pull,
	// resolved wires
	output logic      data_wire,
	output logic      clock_wire,
	output logic      irq_wire
);
	// pull-up wins unless some party pulls low
	assign data_wire  = data_oe_n & ~host_data_pull;
	assign clock_wire = clock_oe_n & ~host_clock_pull;
	assign irq_wire   = irq_oe_n;
endmodule : tcpm_host_model

// ---- hdl/tcpm_consts.svh ----
// timing counts and encodings for the type-c pin mode logic
// included by the package users; definitions only
`ifndef TCPM_CONSTS_SVH
`define TCPM_CONSTS_SVH
`define TCPM_I2C_ADDR_HIGH 7'h67
`define TCPM_I2C_ADDR_LOW  7'h47
`define TCPM_CLK_MHZ       200
`define TCPM_SETTLE_NS     100
`define TCPM_SETTLE_CYC    ((`TCPM_SETTLE_NS * `TCPM_CLK_MHZ) / 1000)
`endif

// ---- hdl/tcpm_od_pin.sv ----
// one open-drain pin: pull low when asserted, released otherwise
// the board pull-up sets the high level
`timescale 1ns/1ps
module tcpm_od_pin (
	input  wire logic ref_clk,
	input  wire logic rstn,
	// request
	input  wire logic pull_low,
	// pin
	output logic      pin_o,
	output logic      pin_oe_n
);
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pin_o    <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			pin_o    <= 1'b0;
			pin_oe_n <= ~pull_low;
		end
	end
endmodule : tcpm_od_pin

// ---- hdl/tcpm_pin_mode.sv ----
// Behaviour
// - a high address strap enables the serial bus at address 0x67.
// - a low address strap enables the serial bus at address 0x47.
// - an open address strap disables the serial bus and selects gpio status outputs.
// - with the bus enabled the shared pins carry bus data and clock driven by the host.
// - in bus mode the interrupt pin is pulled low when internal registers change.
// - in gpio mode the third output is low on audio accessory detection, else high.
// - in gpio mode as ufp the first output is low for medium or high current, else high.
// - in gpio mode as ufp the second output is low only for high current.
// - the vconn fault pin is pulled low on vconn overcurrent.
// - the attach pin is pulled low on attachment while the port acts as source and the cc logic is running.
// - the role strap is sampled on cc enable and after soft reset: high dfp, open drp, low ufp.
// - in gpio mode as dfp the current strap sets the advertised current; ignored as ufp.
// pin mode selection and status pins for a type-c port controller
// straps resolved to tri-level codes outside; cc logic supplies status
`timescale 1ns/1ps
`include "tcpm_consts.svh"
module tcpm_pin_mode (
	// clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rstn,
	// straps and enables
	input  wire tcpm_pkg::tcpm_level_type     addr_strap,
	input  wire tcpm_pkg::tcpm_level_type     port_strap,
	input  wire tcpm_pkg::tcpm_level_type     current_strap,
	input  wire logic                         cc_enable_low,
	input  wire logic                         soft_reset,
	// cc logic status
	input  wire tcpm_pkg::tcpm_cc_status_type cc_status,
	// serial bus engine side, open-drain requests
	input  wire logic                         bus_data_pull,
	input  wire logic                         bus_clock_pull,
	// shared data pin
	input  wire logic                         data_or_current_lo_in,
	output logic                              data_or_current_lo_out,
	output logic                              data_or_current_lo_oe_n,
	// shared clock pin
	input  wire logic                         clock_or_current_hi_in,
	output logic                              clock_or_current_hi_out,
	output logic                              clock_or_current_hi_oe_n,
	// dedicated open-drain pins
	output logic                              irq_or_audio_detect_out,
	output logic                              irq_or_audio_detect_oe_n,
	output logic                              vconn_overcurrent_flag,
	output logic                              vconn_overcurrent_oe_n,
	output logic                              source_attach_out,
	output logic                              source_attach_oe_n,
	// to bus engine and cc logic
	output logic                              bus_data_in,
	output logic                              bus_clock_in,
	output tcpm_pkg::tcpm_bus_mode_type       bus_mode,
	output tcpm_pkg::tcpm_role_type           port_role,
	output tcpm_pkg::tcpm_current_type        advertised_current,
	output logic                              cc_running
);
	logic                       gpio_mode;
	logic                       cc_on_prev;
	logic                       role_sample;
	logic                       ufp_role;
	logic                       dfp_side;
	logic                       pull_lo;
	logic                       pull_hi;
	logic                       pull_irq;
	logic                       pull_vconn;
	logic                       pull_attach;
	tcpm_pkg::tcpm_role_type    next_role;
	tcpm_pkg::tcpm_current_type next_adv;

	function automatic tcpm_pkg::tcpm_role_type role_of(input tcpm_pkg::tcpm_level_type lvl);
		case (lvl)
			tcpm_pkg::TCPM_LVL_HIGH: role_of = tcpm_pkg::TCPM_ROLE_DFP;
			tcpm_pkg::TCPM_LVL_LOW:  role_of = tcpm_pkg::TCPM_ROLE_UFP;
			default:                 role_of = tcpm_pkg::TCPM_ROLE_DRP;
		endcase
	endfunction : role_of

	// bus address strap decode
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bus_mode <= '0;
		end else if (addr_strap == tcpm_pkg::TCPM_LVL_HIGH) begin
			bus_mode <= '{i2c_enabled: 1'b1, i2c_address: `TCPM_I2C_ADDR_HIGH};
		end else if (addr_strap == tcpm_pkg::TCPM_LVL_LOW) begin
			bus_mode <= '{i2c_enabled: 1'b1, i2c_address: `TCPM_I2C_ADDR_LOW};
		end else begin
			bus_mode <= '0;
		end
	end
	assign gpio_mode = ~bus_mode.i2c_enabled;

	// cc enable level is active low
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cc_running <= 1'b0;
			cc_on_prev <= 1'b0;
		end else begin
			cc_running <= ~cc_enable_low;
			cc_on_prev <= cc_running;
		end
	end

	// sample only on enable edge or soft reset, so strap changes mid-session are ignored
	assign role_sample = (cc_running & ~cc_on_prev) | (cc_running & soft_reset);
	assign next_role   = role_sample ? role_of(port_strap) : port_role;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			port_role <= tcpm_pkg::TCPM_ROLE_DRP;
		end else begin
			port_role <= next_role;
		end
	end

	assign ufp_role = (port_role == tcpm_pkg::TCPM_ROLE_UFP) || !cc_status.acting_source;
	assign dfp_side = cc_running && !ufp_role;

	// advertisement from current strap in gpio mode when not ufp
	always_comb begin
		next_adv = tcpm_pkg::TCPM_CUR_DEFAULT;
		if (gpio_mode && dfp_side) begin
			case (current_strap)
				tcpm_pkg::TCPM_LVL_HIGH: next_adv = tcpm_pkg::TCPM_CUR_HIGH;
				tcpm_pkg::TCPM_LVL_OPEN: next_adv = tcpm_pkg::TCPM_CUR_MEDIUM;
				default:                 next_adv = tcpm_pkg::TCPM_CUR_DEFAULT;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			advertised_current <= tcpm_pkg::TCPM_CUR_DEFAULT;
		end else begin
			advertised_current <= next_adv;
		end
	end

	// pull requests per pin
	always_comb begin
		if (!gpio_mode) begin
			pull_lo  = bus_data_pull;
			pull_hi  = bus_clock_pull;
			pull_irq = cc_status.regs_changed;
		end else begin
			pull_lo  = ufp_role && cc_status.detected_current != tcpm_pkg::TCPM_CUR_DEFAULT;
			pull_hi  = ufp_role && cc_status.detected_current == tcpm_pkg::TCPM_CUR_HIGH;
			pull_irq = cc_status.audio_accessory;
		end
	end
	assign pull_vconn  = cc_status.vconn_overcurrent;
	assign pull_attach = cc_status.attached && cc_status.acting_source && cc_running;

	// bus inputs only meaningful in bus mode
	assign bus_data_in  = bus_mode.i2c_enabled ? data_or_current_lo_in : 1'b1;
	assign bus_clock_in = bus_mode.i2c_enabled ? clock_or_current_hi_in : 1'b1;

	// one register stage per pin; bus timing at 200 MHz easily tolerates it
	tcpm_od_pin u_lo (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.pull_low (pull_lo),
		.pin_o    (data_or_current_lo_out),
		.pin_oe_n (data_or_current_lo_oe_n)
	);
	tcpm_od_pin u_hi (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.pull_low (pull_hi),
		.pin_o    (clock_or_current_hi_out),
		.pin_oe_n (clock_or_current_hi_oe_n)
	);
	tcpm_od_pin u_irq (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.pull_low (pull_irq),
		.pin_o    (irq_or_audio_detect_out),
		.pin_oe_n (irq_or_audio_detect_oe_n)
	);
	tcpm_od_pin u_vconn (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.pull_low (pull_vconn),
		.pin_o    (vconn_overcurrent_flag),
		.pin_oe_n (vconn_overcurrent_oe_n)
	);
	tcpm_od_pin u_attach (
		.ref_clk  (ref_clk),
		.rstn     (rstn),
		.pull_low (pull_attach),
		.pin_o    (source_attach_out),
		.pin_oe_n (source_attach_oe_n)
	);

	property p_addr_high;
		@(posedge ref_clk) disable iff (!rstn)
		addr_strap == tcpm_pkg::TCPM_LVL_HIGH |=> bus_mode.i2c_enabled && bus_mode.i2c_address == 7'h67;
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("high strap address wrong");

	property p_addr_low;
		@(posedge ref_clk) disable iff (!rstn)
		addr_strap == tcpm_pkg::TCPM_LVL_LOW |=> bus_mode.i2c_enabled && bus_mode.i2c_address == 7'h47;
	endproperty
	a_addr_low: assert property (p_addr_low) else $error("low strap address wrong");

	property p_gpio_sel;
		@(posedge ref_clk) disable iff (!rstn)
		addr_strap == tcpm_pkg::TCPM_LVL_OPEN |=> !bus_mode.i2c_enabled;
	endproperty
	a_gpio_sel: assert property (p_gpio_sel) else $error("open strap left bus enabled");

	property p_bus_data;
		@(posedge ref_clk) disable iff (!rstn)
		bus_mode.i2c_enabled && bus_data_pull |=> !data_or_current_lo_oe_n;
	endproperty
	a_bus_data: assert property (p_bus_data) else $error("bus data pull not driven");

	property p_irq;
		@(posedge ref_clk) disable iff (!rstn)
		bus_mode.i2c_enabled && cc_status.regs_changed |=> !irq_or_audio_detect_oe_n;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not pulled");

	property p_audio;
		@(posedge ref_clk) disable iff (!rstn)
		gpio_mode |=> irq_or_audio_detect_oe_n == !$past(cc_status.audio_accessory);
	endproperty
	a_audio: assert property (p_audio) else $error("audio output wrong");

	property p_cur_hi;
		@(posedge ref_clk) disable iff (!rstn)
		gpio_mode && ufp_role && cc_status.detected_current == tcpm_pkg::TCPM_CUR_HIGH
			|=> !data_or_current_lo_oe_n && !clock_or_current_hi_oe_n;
	endproperty
	a_cur_hi: assert property (p_cur_hi) else $error("high current outputs wrong");

	property p_cur_med;
		@(posedge ref_clk) disable iff (!rstn)
		gpio_mode && ufp_role && cc_status.detected_current == tcpm_pkg::TCPM_CUR_MEDIUM
			|=> !data_or_current_lo_oe_n && clock_or_current_hi_oe_n;
	endproperty
	a_cur_med: assert property (p_cur_med) else $error("medium current outputs wrong");

	property p_vconn;
		@(posedge ref_clk) disable iff (!rstn)
		cc_status.vconn_overcurrent |=> !vconn_overcurrent_oe_n ##1 1'b1;
	endproperty
	a_vconn: assert property (p_vconn) else $error("vconn fault not pulled");

	property p_attach;
		@(posedge ref_clk) disable iff (!rstn)
		!cc_status.acting_source |=> source_attach_oe_n;
	endproperty
	a_attach: assert property (p_attach) else $error("attach shown while sink");

	property p_role;
		@(posedge ref_clk) disable iff (!rstn)
		role_sample && port_strap == tcpm_pkg::TCPM_LVL_LOW |=> port_role == tcpm_pkg::TCPM_ROLE_UFP;
	endproperty
	a_role: assert property (p_role) else $error("role strap not sampled");

	property p_adv;
		@(posedge ref_clk) disable iff (!rstn)
		gpio_mode && dfp_side && current_strap == tcpm_pkg::TCPM_LVL_HIGH
			|=> advertised_current == tcpm_pkg::TCPM_CUR_HIGH;
	endproperty
	a_adv: assert property (p_adv) else $error("advertised current wrong");

	property p_bus_clock;
		@(posedge ref_clk) disable iff (!rstn)
		bus_mode.i2c_enabled |=> clock_or_current_hi_oe_n == !$past(bus_clock_pull);
	endproperty
	a_bus_clock: assert property (p_bus_clock) else $error("bus clock pull not followed");

	property p_cur_def;
		@(posedge ref_clk) disable iff (!rstn)
		gpio_mode && ufp_role && cc_status.detected_current == tcpm_pkg::TCPM_CUR_DEFAULT
			|=> data_or_current_lo_oe_n && clock_or_current_hi_oe_n;
	endproperty
	a_cur_def: assert property (p_cur_def) else $error("default current outputs wrong");

	// a source never reports detected current, both outputs stay released
	property p_cur_src;
		@(posedge ref_clk) disable iff (!rstn)
		gpio_mode && !ufp_role |=> data_or_current_lo_oe_n && clock_or_current_hi_oe_n;
	endproperty
	a_cur_src: assert property (p_cur_src) else $error("current outputs pulled while source");

	property p_vconn_off;
		@(posedge ref_clk) disable iff (!rstn)
		!cc_status.vconn_overcurrent |=> vconn_overcurrent_oe_n;
	endproperty
	a_vconn_off: assert property (p_vconn_off) else $error("vconn fault pulled without fault");

	property p_attach_on;
		@(posedge ref_clk) disable iff (!rstn)
		cc_status.attached && cc_status.acting_source && cc_running |=> !source_attach_oe_n;
	endproperty
	a_attach_on: assert property (p_attach_on) else $error("attach not shown while source");

	property p_role_hold;
		@(posedge ref_clk) disable iff (!rstn)
		!role_sample |=> $stable(port_role);
	endproperty
	a_role_hold: assert property (p_role_hold) else $error("role changed without sample");

	property p_adv_dflt;
		@(posedge ref_clk) disable iff (!rstn)
		!(gpio_mode && dfp_side) |=> advertised_current == tcpm_pkg::TCPM_CUR_DEFAULT;
	endproperty
	a_adv_dflt: assert property (p_adv_dflt) else $error("advertised current not default");
endmodule : tcpm_pin_mode

// ---- hdl/tcpm_pkg.sv ----
// types for the type-c pin mode logic
// tri-level straps arrive already resolved to two bits
package tcpm_pkg;
	typedef enum logic [1:0] {
		TCPM_LVL_LOW  = 2'h0,
		TCPM_LVL_OPEN = 2'h1,
		TCPM_LVL_HIGH = 2'h2
	} tcpm_level_type;

	typedef enum logic [1:0] {
		TCPM_CUR_DEFAULT = 2'h0,
		TCPM_CUR_MEDIUM  = 2'h1,
		TCPM_CUR_HIGH    = 2'h2
	} tcpm_current_type;

	typedef enum logic [2:0] {
		TCPM_ROLE_UFP = 3'h1,
		TCPM_ROLE_DRP = 3'h2,
		TCPM_ROLE_DFP = 3'h4
	} tcpm_role_type;

	typedef struct packed {
		logic             attached;
		logic             acting_source;
		tcpm_current_type detected_current;
		logic             audio_accessory;
		logic             vconn_overcurrent;
		logic             regs_changed;
	} tcpm_cc_status_type;

	typedef struct packed {
		logic       i2c_enabled;
		logic [6:0] i2c_address;
	} tcpm_bus_mode_type;
endpackage : tcpm_pkg
